// file: design/btis_pkg.sv
// Behaviour
// - A read/write input-select register chooses which backplane lines feed the trigger.
// - Several selected lines are ORed; any one of them triggers the board.
// - Select value zero ignores all lines; the internal trigger is used instead.
// - Lines 0 to 5 map to bits 1..32, the star line to 256.
// - Read-only capability field: bits 1..128 mark lines 0-7, 256 the star line.
// - Only the lower sixteen capability bits carry meaning; higher bits read zero.
// - Trigger timing may vary by up to one sample between boards.
// - Line OR combined with channel OR lets any event trigger the whole system.
// - A board routing its own trigger to a line does not self-trigger directly.
// - A line event is a rising edge; the line returns low by stop.
// - Trigger detection is enabled only while pretrigger-done line 7 reads high.
package btis_pkg;

    // ------------------------------------------------------------
    // Register map (indices; byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [15:0] BTIS_IDX_INPUT_SELECT = 16'h9D76;
    localparam logic [15:0] BTIS_IDX_INPUT_CAP    = 16'h9D77;
    localparam logic [15:0] BTIS_IDX_OUTPUT_ROUTE = 16'h9D6C;
    localparam logic [15:0] BTIS_IDX_STATUS       = 16'h9D80;
    localparam int          BTIS_ADDR_W           = 18;
    localparam logic [17:0] BTIS_ADDR_SELECT      = {BTIS_IDX_INPUT_SELECT, 2'b00};
    localparam logic [17:0] BTIS_ADDR_CAP         = {BTIS_IDX_INPUT_CAP, 2'b00};
    localparam logic [17:0] BTIS_ADDR_ROUTE       = {BTIS_IDX_OUTPUT_ROUTE, 2'b00};
    localparam logic [17:0] BTIS_ADDR_STATUS      = {BTIS_IDX_STATUS, 2'b00};

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int          BTIS_NUM_LINES  = 8;
    localparam int          BTIS_SEL_LINES  = 6;
    localparam int          BTIS_STAR_BIT   = 8;
    localparam int          BTIS_FIELD_W    = 9;
    localparam int          BTIS_CAP_W      = 16;
    localparam int          BTIS_READY_LINE = 7;
    localparam logic [8:0]  BTIS_SEL_MASK   = 9'h13F;
    localparam logic [8:0]  BTIS_SEL_RESET  = 9'h000;
    localparam logic [15:0] BTIS_CAP_RESET  = 16'h01FF;
    localparam logic [3:0]  BTIS_ROUTE_OFF  = 4'h0;
    localparam logic [3:0]  BTIS_ROUTE_STAR = 4'h9;
    localparam logic [3:0]  BTIS_ROUTE_MAX  = 4'h6;
    localparam logic [1:0]  BTIS_RESP_OKAY  = 2'b00;
    localparam logic [1:0]  BTIS_RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [BTIS_NUM_LINES-1:0] line;
        logic                      star;
    } btis_lines_type;

    typedef struct packed {
        logic        trigger;
        logic        internal_used;
        logic        armed;
    } btis_status_type;

endpackage : btis_pkg

// file: design/btis_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser, one per bit
// ----------------------------------------------------------------
module btis_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : btis_sync

// file: design/btis_top.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module btis_top
    import btis_pkg::*;
#(
    parameter logic [15:0] CAPABILITY = BTIS_CAP_RESET
) (
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_in,
    // AXI4-Lite slave
    input  wire logic [BTIS_ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                   s_axi_awvalid_in,
    output logic                        s_axi_awready_out,
    input  wire logic [31:0]            s_axi_wdata_in,
    input  wire logic [3:0]             s_axi_wstrb_in,
    input  wire logic                   s_axi_wvalid_in,
    output logic                        s_axi_wready_out,
    output logic [1:0]                  s_axi_bresp_out,
    output logic                        s_axi_bvalid_out,
    input  wire logic                   s_axi_bready_in,
    input  wire logic [BTIS_ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                   s_axi_arvalid_in,
    output logic                        s_axi_arready_out,
    output logic [31:0]                 s_axi_rdata_out,
    output logic [1:0]                  s_axi_rresp_out,
    output logic                        s_axi_rvalid_out,
    input  wire logic                   s_axi_rready_in,
    // Backplane trigger lines; ready line 7 open drain, routed lines and star driven both ways
    input  wire logic [7:0]             trig_line_in,
    input  wire logic                   star_line_in,
    output logic [7:0]                  trig_line_out,
    output logic [7:0]                  trig_line_oe_out,
    output logic                        star_line_out,
    output logic                        star_line_oe_out,
    // Board trigger logic
    input  wire logic                   internal_trig_in,
    input  wire logic                   pretrig_done_in,
    input  wire logic                   board_running_in,
    output logic                        trigger_out
);

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [BTIS_FIELD_W-1:0] select_r;
    logic [3:0]              route_r;
    logic                    aw_held_r;
    logic                    w_held_r;
    logic [BTIS_ADDR_W-1:0]  awaddr_r;
    logic [31:0]             wdata_r;
    logic [3:0]              wstrb_r;
    logic                    trig_prev_r;
    logic                    trigger_r;
    logic                    route_level_r;
    logic                    ready_drv_r;
    btis_lines_type          lines_s;
    btis_status_type         status_s;
    logic [8:0]              raw_s;
    logic [8:0]              sync_s;
    logic [2:0]              local_s;
    logic [2:0]              local_sync_s;
    logic                    line_or_s;
    logic                    armed_s;
    logic                    rise_s;
    logic                    own_rise_s;
    logic                    int_prev_r;
    logic                    do_write_s;

    // Address decode used by both channels
    function automatic logic is_mapped(input logic [BTIS_ADDR_W-1:0] a);
        return (a == BTIS_ADDR_SELECT) || (a == BTIS_ADDR_CAP) ||
               (a == BTIS_ADDR_ROUTE) || (a == BTIS_ADDR_STATUS);
    endfunction : is_mapped

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    // Line bits first, star last, to match the carrier's field order
    assign raw_s   = {trig_line_in, star_line_in};
    assign local_s = {board_running_in, pretrig_done_in, internal_trig_in};

    btis_sync #(.WIDTH(9)) u_line_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .async_in   (raw_s),
        .sync_out   (sync_s)
    );

    btis_sync #(.WIDTH(3)) u_local_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .async_in   (local_s),
        .sync_out   (local_sync_s)
    );

    assign lines_s = btis_lines_type'(sync_s);

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    // Bits 0..5 pick lines 0..5, bit 8 the star line
    assign line_or_s = |(lines_s.line[BTIS_SEL_LINES-1:0] & select_r[BTIS_SEL_LINES-1:0])
                     | (lines_s.star & select_r[BTIS_STAR_BIT]);

    // Open-collector ready line gates all detection
    assign armed_s    = lines_s.line[BTIS_READY_LINE];
    assign rise_s     = line_or_s & ~trig_prev_r;
    assign own_rise_s = local_sync_s[0] & ~int_prev_r;

    // Edge history
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_prev_r <= 1'b0;
            int_prev_r  <= 1'b0;
        end else begin
            trig_prev_r <= line_or_s;
            int_prev_r  <= local_sync_s[0];
        end
    end

    // Board trigger pulse; sync delay costs the one-sample skew
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            trigger_r <= 1'b0;
        end else if (!armed_s) begin
            trigger_r <= 1'b0;
        end else if (select_r != BTIS_SEL_RESET) begin
            trigger_r <= rise_s;
        end else if (route_r != BTIS_ROUTE_OFF) begin
            trigger_r <= 1'b0;
        end else begin
            trigger_r <= own_rise_s;
        end
    end
    assign trigger_out = trigger_r;

    // Own trigger driven on the routed line until the board stops
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            route_level_r <= 1'b0;
        end else if (!local_sync_s[2]) begin
            route_level_r <= 1'b0;
        end else if (own_rise_s && armed_s) begin
            route_level_r <= 1'b1;
        end
    end

    // Ready line held low until pretrigger done
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_drv_r <= 1'b1;
        end else begin
            ready_drv_r <= ~local_sync_s[1];
        end
    end

    // Output drivers; ready line high is left to the pull-up, routed lines drive both levels
    for (genvar g = 0; g < BTIS_NUM_LINES; g++) begin : g_drv
        if (g == BTIS_READY_LINE) begin : g_rdy
            assign trig_line_out[g]    = 1'b0;
            assign trig_line_oe_out[g] = ready_drv_r;
        end else begin : g_trg
            assign trig_line_out[g]    = route_level_r;
            assign trig_line_oe_out[g] = (route_r == 4'(g + 1));
        end
    end
    assign star_line_out    = route_level_r;
    assign star_line_oe_out = (route_r == BTIS_ROUTE_STAR);

    assign status_s = '{trigger: trigger_r, internal_used: (select_r == BTIS_SEL_RESET), armed: armed_s};

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready_out = ~aw_held_r & ~s_axi_bvalid_out;
    assign s_axi_wready_out  = ~w_held_r & ~s_axi_bvalid_out;
    assign do_write_s        = aw_held_r & w_held_r & ~s_axi_bvalid_out;

    // Address and data may arrive in either order
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr_in;
            end else if (do_write_s) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata_in;
                wstrb_r  <= s_axi_wstrb_in;
            end else if (do_write_s) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Register writes; unselectable bits are dropped
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            select_r <= BTIS_SEL_RESET;
            route_r  <= BTIS_ROUTE_OFF;
        end else if (do_write_s) begin
            if (awaddr_r == BTIS_ADDR_SELECT) begin
                if (wstrb_r[0]) select_r[7:0] <= wdata_r[7:0] & BTIS_SEL_MASK[7:0];
                if (wstrb_r[1]) select_r[8]   <= wdata_r[8] & BTIS_SEL_MASK[8];
            end else if (awaddr_r == BTIS_ADDR_ROUTE && wstrb_r[0]) begin
                if (wdata_r[3:0] <= BTIS_ROUTE_MAX || wdata_r[3:0] == BTIS_ROUTE_STAR) begin
                    route_r <= wdata_r[3:0];
                end
            end
        end
    end

    // Write response
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= BTIS_RESP_OKAY;
        end else if (do_write_s) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= is_mapped(awaddr_r) ? BTIS_RESP_OKAY : BTIS_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready_out = ~s_axi_rvalid_out;

    // Read data; capability upper bits stay zero
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= '0;
            s_axi_rresp_out  <= BTIS_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= is_mapped(s_axi_araddr_in) ? BTIS_RESP_OKAY : BTIS_RESP_SLVERR;
            case (s_axi_araddr_in)
                BTIS_ADDR_SELECT: s_axi_rdata_out <= {23'h000000, select_r};
                BTIS_ADDR_CAP:    s_axi_rdata_out <= {16'h0000, CAPABILITY};
                BTIS_ADDR_ROUTE:  s_axi_rdata_out <= {28'h0000000, route_r};
                BTIS_ADDR_STATUS: s_axi_rdata_out <= {29'h00000000, status_s};
                default:          s_axi_rdata_out <= 32'h00000000;
            endcase
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

endmodule : btis_top

// file: verif/btis_checker.sv
`timescale 1ns/1ps
module btis_checker
    import btis_pkg::*;
#(
    parameter logic [15:0] CAPABILITY = BTIS_CAP_RESET
) (
    input wire logic                   ref_clk_in,
    input wire logic                   rst_in,
    input wire logic                   s_axi_awready_out,
    input wire logic                   s_axi_bvalid_out,
    input wire logic                   s_axi_bready_in,
    input wire logic [BTIS_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic                   s_axi_rvalid_out,
    input wire logic                   s_axi_rready_in,
    input wire logic [31:0]            s_axi_rdata_out,
    input wire logic [7:0]             trig_line_in,
    input wire logic                   star_line_in,
    input wire logic [7:0]             trig_line_out,
    input wire logic [7:0]             trig_line_oe_out,
    input wire logic                   internal_trig_in,
    input wire logic                   pretrig_done_in,
    input wire logic                   trigger_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // ----------------
    // Register bus
    // ----------------
    bvalid_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write answer dropped early");
    write_refused_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && $past(!s_axi_awready_out))
        else $error("write answer without held address");
    rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> $stable(s_axi_rdata_out))
        else $error("read data moved before taken");
    cap_read_a: assert property ($rose(s_axi_rvalid_out) && $past(s_axi_araddr_in) == BTIS_ADDR_CAP
        |-> s_axi_rdata_out == {16'h0000, CAPABILITY})
        else $error("capability field wrong");

    // ----------------
    // Trigger path
    // ----------------
    trig_pulse_a: assert property (trigger_out |=> !trigger_out)
        else $error("trigger longer than one cycle");
    ready_gate_a: assert property (!trig_line_in[7] [*8] |-> !trigger_out)
        else $error("trigger while ready line low");
    line7_pull_a: assert property (!pretrig_done_in [*4] |-> trig_line_oe_out[7] && !trig_line_out[7])
        else $error("ready line not pulled low");
    no_cause_a: assert property ((trig_line_in[5:0] == 6'h00 && !star_line_in && !internal_trig_in) [*8]
        |-> !trigger_out)
        else $error("trigger without any source");
endmodule : btis_checker

// file: verif/btis_boards.sv
`timescale 1ns/1ps
module btis_boards
    import btis_pkg::*;
#(
    parameter int HOLD = 3
) (
    input  wire logic       ref_clk_in,
    input  wire logic [8:0] fire_in,
    input  wire logic       busy_in,
    input  wire logic [7:0] dut_out_in,
    input  wire logic [7:0] dut_oe_in,
    input  wire logic       dut_star_in,
    input  wire logic       dut_star_oe_in,
    output logic [7:0]      line_out,
    output logic            star_out
);
    int         cnt [9] = '{default: 0};
    logic [8:0] lvl;

    // One board owns each line; an event is a rising edge, low again after HOLD
    always @(posedge ref_clk_in) begin
        for (int i = 0; i < 9; i++) begin
            if (fire_in[i])
                cnt[i] <= HOLD;
            else if (cnt[i] > 0)
                cnt[i] <= cnt[i] - 1;
        end
    end

    // Line 7 has a pull-up; any board in pretrigger holds it low
    always_comb begin
        for (int i = 0; i < 9; i++)
            lvl[i] = cnt[i] > 0;
        for (int i = 0; i < 7; i++)
            line_out[i] = dut_oe_in[i] ? dut_out_in[i] : lvl[i];
        line_out[7] = !busy_in && !(dut_oe_in[7] && !dut_out_in[7]);
        star_out = dut_star_oe_in ? dut_star_in : lvl[8];
    end
endmodule : btis_boards

// file: verif/btis_top_tb.sv
`timescale 1ns/1ps
module btis_top_tb;
    import btis_pkg::*;
    logic        clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awready, wready, bvalid, arready, rvalid, trig, star_in, star_o, star_oe;
    logic [1:0]  bresp, rresp;
    logic [7:0]  line_in, line_o, line_oe;
    logic [8:0]  fire = '0;
    logic        busy = 1'h1, itrig = 1'h0, pdone = 1'h0, run = 1'h1;
    int          n_mismatch = 0, tests_run = 0, cyc = 0, n_trig = 0, sel_m = 0, route_m = 0;

    initial forever #2.5 clk = ~clk;

    btis_top dut (.ref_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .trig_line_in(line_in),
        .star_line_in(star_in), .trig_line_out(line_o), .trig_line_oe_out(line_oe), .star_line_out(star_o),
        .star_line_oe_out(star_oe), .internal_trig_in(itrig), .pretrig_done_in(pdone),
        .board_running_in(run), .trigger_out(trig));
    btis_boards bp (.ref_clk_in(clk), .fire_in(fire), .busy_in(busy), .dut_out_in(line_o), .dut_oe_in(line_oe),
        .dut_star_in(star_o), .dut_star_oe_in(star_oe), .line_out(line_in), .star_out(star_in));

    // Cycle count, trigger count and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (trig === 1'h1)
            n_trig <= n_trig + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Address and data offered together, each released when taken
    task automatic wr(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ap, wp;
        ap = 1'h1;
        wp = 1'h1;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        while (ap || wp) begin
            @(posedge clk);
            ap = ap && !awready;
            wp = wp && !wready;
            awv <= ap;
            wv <= wp;
        end
        while (bvalid !== 1'h1) @(posedge clk);
        bready <= 1'h1;
        @(posedge clk);
        r = bresp;
        bready <= 1'h0;
    endtask : wr

    // Late rready so the slave must hold its answer
    task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arv <= 1'h1;
        do @(posedge clk); while (arready !== 1'h1);
        arv <= 1'h0;
        while (rvalid !== 1'h1) @(posedge clk);
        rready <= 1'h1;
        @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : rd

    // Fire one line (9 = none) and optionally the own trigger, then count pulses
    task automatic shot(input int k, input logic it);
        int n0, e;
        @(posedge clk);
        n0 = n_trig;
        fire <= 9'h001 << k;
        itrig <= it;
        @(posedge clk);
        fire <= 9'h000;
        repeat (12) @(posedge clk);
        itrig <= 1'h0;
        repeat (3) @(posedge clk);
        e = busy ? 0 : (sel_m == 0) ? int'(it && route_m == 0) : (k < 9) ? sel_m[k] : 0;
        chk("trigger count", e, n_trig - n0);
    endtask : shot

    task automatic wrap_up;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        logic [31:0] d, v;
        logic [1:0]  r;
        void'($urandom(32'h5075));
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        rd(BTIS_ADDR_SELECT, d, r);
        chk("select reset", 32'h0, d);
        wr(BTIS_ADDR_CAP, 32'hFFFFFFFF, r);
        rd(BTIS_ADDR_CAP, d, r);
        chk("capability", {16'h0000, BTIS_CAP_RESET}, d);
        rd(18'h00010, d, r);
        chk("unmapped response", BTIS_RESP_SLVERR, r);
        // Ready line held low by a board still in pretrigger
        wr(BTIS_ADDR_SELECT, 32'h13F, r);
        chk("write response", BTIS_RESP_OKAY, r);
        sel_m = 32'h13F;
        shot(0, 1'h0);
        busy <= 1'h0;
        pdone <= 1'h1;
        // Every line code except 7, random bitmaps, zero once
        for (int k = 0; k < 10; k++) begin
            if (k == 7)
                continue;
            v = (k == 0) ? 32'h0 : $urandom;
            wr(BTIS_ADDR_SELECT, v, r);
            sel_m = v & {23'h0, BTIS_SEL_MASK};
            rd(BTIS_ADDR_SELECT, d, r);
            chk("select", sel_m, d);
            shot(k, 1'($urandom));
        end
        // Own trigger routed out never fires the board itself
        wr(BTIS_ADDR_ROUTE, 32'h1, r);
        route_m = 1;
        wr(BTIS_ADDR_SELECT, 32'h0, r);
        sel_m = 0;
        chk("route enable", 32'h1, {31'h0, line_oe[0]});
        // Status: armed, internal trigger in use, no pulse pending
        rd(BTIS_ADDR_STATUS, d, r);
        chk("status", 32'h3, d);
        shot(9, 1'h1);
        // Star route shows the held own-trigger level until the board stops
        wr(BTIS_ADDR_ROUTE, 32'h9, r);
        chk("star enable", 32'h1, {31'h0, star_oe});
        chk("star level", 32'h1, {31'h0, star_o});
        run <= 1'h0;
        repeat (5) @(posedge clk);
        chk("star released", 32'h0, {31'h0, star_o});
        wrap_up();
    end
endmodule : btis_top_tb

bind btis_top btis_checker #(.CAPABILITY(CAPABILITY)) chk_i (.ref_clk_in, .rst_in, .s_axi_awready_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .trig_line_in, .star_line_in, .trig_line_out, .trig_line_oe_out, .internal_trig_in,
    .pretrig_done_in, .trigger_out);
